// *** core/cit_timing_regs.svh ***
`ifndef CIT_TIMING_REGS_SVH
`define CIT_TIMING_REGS_SVH

// ----------------------------------------
// Timing entries: clocks, reads, writes
// ----------------------------------------
`define CIT_T_SHIFT_BW      {11'h006, 8'h01, 8'h00}
`define CIT_T_SHIFT_L       {11'h008, 8'h01, 8'h00}
`define CIT_T_SHIFT_STEP    {11'h002, 8'h00, 8'h00}
`define CIT_T_SHIFT_MEM     {11'h009, 8'h01, 8'h01}
`define CIT_T_BIT_MEM_DYN   {11'h009, 8'h01, 8'h01}
`define CIT_T_BIT_MEM_IMM   {11'h00D, 8'h02, 8'h01}
`define CIT_T_BIT_REG_DYN   {11'h008, 8'h01, 8'h00}
`define CIT_T_BIT_REG_IMM   {11'h00C, 8'h02, 8'h00}
`define CIT_T_BIT_CLEAR_REG_DYN  {11'h00A, 8'h01, 8'h00}
`define CIT_T_BIT_CLEAR_REG_IMM  {11'h00E, 8'h02, 8'h00}
`define CIT_T_BR_TAKEN      {11'h00A, 8'h01, 8'h00}
`define CIT_T_BR_NOT_B      {11'h008, 8'h01, 8'h00}
`define CIT_T_BR_NOT_W      {11'h00C, 8'h02, 8'h00}
`define CIT_T_JMP_IND       {11'h008, 8'h02, 8'h00}
`define CIT_T_JMP_D16       {11'h00A, 8'h02, 8'h00}
`define CIT_T_JMP_IDX       {11'h00E, 8'h03, 8'h00}
`define CIT_T_JMP_ABSL      {11'h00C, 8'h03, 8'h00}
`define CIT_T_JSR_IND       {11'h012, 8'h02, 8'h02}
`define CIT_T_JSR_D16       {11'h014, 8'h02, 8'h02}
`define CIT_T_JSR_IDX       {11'h018, 8'h02, 8'h02}
`define CIT_T_JSR_ABSL      {11'h016, 8'h03, 8'h02}
`define CIT_T_LEA_IND       {11'h004, 8'h01, 8'h00}
`define CIT_T_LEA_D16       {11'h008, 8'h02, 8'h00}
`define CIT_T_LEA_IDX       {11'h00C, 8'h02, 8'h00}
`define CIT_T_LEA_ABSL      {11'h00C, 8'h03, 8'h00}
`define CIT_T_PEA_IND       {11'h00E, 8'h01, 8'h02}
`define CIT_T_PEA_D16       {11'h012, 8'h02, 8'h02}
`define CIT_T_PEA_IDX       {11'h016, 8'h02, 8'h02}
`define CIT_T_PEA_ABSL      {11'h016, 8'h03, 8'h02}
`define CIT_T_MLD_IND       {11'h00C, 8'h03, 8'h00}
`define CIT_T_MLD_D16       {11'h010, 8'h04, 8'h00}
`define CIT_T_MLD_IDX       {11'h012, 8'h04, 8'h00}
`define CIT_T_MLD_ABSL      {11'h014, 8'h05, 8'h00}
`define CIT_T_MLD_STEP_W    {11'h004, 8'h01, 8'h00}
`define CIT_T_MLD_STEP_L    {11'h008, 8'h02, 8'h00}
`define CIT_T_MST_IND       {11'h008, 8'h02, 8'h00}
`define CIT_T_MST_D16       {11'h00C, 8'h03, 8'h00}
`define CIT_T_MST_IDX       {11'h00E, 8'h03, 8'h00}
`define CIT_T_MST_ABSL      {11'h010, 8'h04, 8'h00}
`define CIT_T_MST_STEP_W    {11'h005, 8'h00, 8'h01}
`define CIT_T_MST_STEP_L    {11'h00A, 8'h00, 8'h02}
`define CIT_T_MP_REG_BW     {11'h004, 8'h01, 8'h00}
`define CIT_T_MP_REG_L      {11'h008, 8'h01, 8'h00}
`define CIT_T_MP_MEM_BW     {11'h012, 8'h03, 8'h01}
`define CIT_T_MP_MEM_L      {11'h01E, 8'h05, 8'h02}
`define CIT_T_SR_RD_REG     {11'h006, 8'h01, 8'h00}
`define CIT_T_SR_RD_MEM     {11'h009, 8'h01, 8'h01}
`define CIT_T_SR_WR         {11'h00C, 8'h02, 8'h00}
`define CIT_T_ALT_W         {11'h012, 8'h02, 8'h02}
`define CIT_T_ALT_L         {11'h01C, 8'h02, 8'h04}
`define CIT_T_EXG           {11'h006, 8'h01, 8'h00}
`define CIT_T_LINK          {11'h012, 8'h02, 8'h02}
`define CIT_T_SHORT         {11'h004, 8'h01, 8'h00}
`define CIT_T_EXT_RESET     {11'h084, 8'h01, 8'h00}
`define CIT_T_RTE           {11'h014, 8'h05, 8'h00}
`define CIT_T_RTS           {11'h010, 8'h04, 8'h00}
`define CIT_T_EXC_FAULT     {11'h039, 8'h04, 8'h07}
`define CIT_T_EXC_INT       {11'h02F, 8'h05, 8'h03}
`define CIT_T_EXC_PLAIN     {11'h025, 8'h04, 8'h03}
`define CIT_IACK_NOM_CLK    4'h4

`endif

// *** core/cit_pkg.sv ***
package cit_pkg;

   typedef enum logic [5:0] {
      OP_ARITH_SHIFT = 6'h00, OP_LOGIC_SHIFT = 6'h01, OP_ROTATE = 6'h02, OP_ROTATE_EXT = 6'h03,
      OP_BIT_TOGGLE = 6'h04, OP_BIT_CLEAR = 6'h05, OP_BIT_SET = 6'h06, OP_COND_BRANCH = 6'h07,
      OP_UNCOND_JUMP = 6'h08, OP_SUBROUTINE_CALL = 6'h09, OP_LOAD_EFF_ADDR = 6'h0A,
      OP_PUSH_EFF_ADDR = 6'h0B, OP_MULTI_LOAD = 6'h0C, OP_MULTI_STORE = 6'h0D, OP_MULTI_PREC = 6'h0E,
      OP_STATUS_READ = 6'h0F, OP_COND_CODE_WRITE = 6'h10, OP_STATUS_WRITE = 6'h11,
      OP_ALT_BYTE_MOVE = 6'h12, OP_REG_EXCHANGE = 6'h13, OP_LINK_FRAME = 6'h14,
      OP_USER_STACK_PTR = 6'h15, OP_NO_OPERATION = 6'h16, OP_EXT_RESET = 6'h17,
      OP_EXCEPTION_RETURN = 6'h18, OP_RETURN_RESTORE = 6'h19, OP_SUB_RETURN = 6'h1A,
      OP_EXC_ADDR = 6'h1B, OP_EXC_BUS = 6'h1C, OP_EXC_INT = 6'h1D, OP_EXC_ILLEGAL = 6'h1E,
      OP_EXC_PRIV = 6'h1F, OP_EXC_TRACE = 6'h20
   } cit_op_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
   } cit_size_t;

   typedef enum logic [3:0] {
      M_DATA_REG = 4'h0, M_ADDR_REG = 4'h1, M_IND = 4'h2, M_POSTINC = 4'h3, M_PREDEC = 4'h4,
      M_DISP = 4'h5, M_INDEX = 4'h6, M_ABS_SHORT = 4'h7, M_ABS_LONG = 4'h8, M_PC_DISP = 4'h9,
      M_PC_INDEX = 4'hA, M_IMMED = 4'hB
   } cit_mode_t;

   typedef enum logic [2:0] {
      C_IND = 3'h0, C_D16 = 3'h1, C_IDX = 3'h2, C_ABSL = 3'h3, C_NONE = 3'h4
   } cit_class_t;

   typedef struct packed {
      logic [10:0] clk;
      logic [7:0] rd;
      logic [7:0] wr;
   } cit_tm_t;

   typedef struct packed {
      cit_tm_t tm;
      logic ea_add;
      logic legal;
      logic max_val;
   } cit_res_t;

endpackage

// *** core/cit_seq_if.sv ***
`timescale 1ns/1ps
interface cit_seq_if;
   logic load;
   logic [10:0] total;
   logic stop;
   logic busy;
   logic last;
   modport ctl (output load, output total, output stop, input busy, input last);
   modport cnt (input load, input total, input stop, output busy, output last);
endinterface

// *** core/cit_cycle_cnt.sv ***
`timescale 1ns/1ps
module cit_cycle_cnt (
   input wire logic mclk_in,
   input wire logic rst_in,
   cit_seq_if.cnt seq
);
   logic [10:0] rem_ff;
   logic busy_ff;

   // ----------------------------------------
   // Clock period countdown
   // ----------------------------------------
   assign seq.busy = busy_ff;
   assign seq.last = busy_ff && ((rem_ff == 11'h000) || seq.stop);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         busy_ff <= 1'b0;
      end else if (seq.load) begin
         busy_ff <= 1'b1;
      end else if (seq.last) begin
         busy_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rem_ff <= 11'h000;
      end else if (seq.load) begin
         rem_ff <= seq.total - 11'h001;
      end else if (busy_ff && (rem_ff != 11'h000)) begin
         rem_ff <= rem_ff - 11'h001;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   load_busy_a: assert property (@(posedge mclk_in) disable iff (rst_in)
      seq.load |=> busy_ff && rem_ff == $past(seq.total) - 11'h001)
      else $error("countdown not started by load");
endmodule

// *** core/cit_timing.sv ***
`timescale 1ns/1ps
`include "cit_timing_regs.svh"
// Function
// - Register shifts: 6+2n or 8+2n clocks
// - Memory shifts word only, 9 clocks
// - Bit ops: memory 9/13, register 8/12, 10/14
// - Branch: 10 taken, 8 or 12 not
// - Multi-register load: 12+4n or 12+8n clocks
// - Multi-register store: 8+5n/8+10n, restricted modes
// - Index size never changes the clock count
// - Multi-precision counts are complete totals
// - Exception counts include stacking, vector, fetch
// - Address and bus error: 57 clocks
// - Interrupt 47 clocks with four-clock acknowledge
// - Illegal, privilege, trace: 37 clocks
// - External reset instruction takes 132 clocks
// - Returns: 20 clocks five reads, 16 four
// - Alternate-byte move: 18 or 28 clocks
// - Status write 12, status read 6/9
// - Link 18, short ops 4, exchange 6
// - Marked entries add address calculation time
module cit_timing (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input cit_pkg::cit_op_t op_in,
   input cit_pkg::cit_size_t size_in,
   input cit_pkg::cit_mode_t mode_in,
   input wire logic [5:0] count_in,
   input wire logic taken_in,
   input wire logic imm_bit_in,
   input wire logic mem_form_in,
   input wire logic [7:0] ea_clk_in,
   input wire logic [3:0] ea_rd_in,
   input wire logic [3:0] ea_wr_in,
   input wire logic [3:0] iack_clk_in,
   input wire logic early_in,
   output logic ready_out,
   output logic busy_out,
   output logic done_out,
   output logic illegal_out,
   output logic [10:0] clocks_out,
   output logic [7:0] reads_out,
   output logic [7:0] writes_out,
   output logic max_out
);
   import cit_pkg::*;

   cit_seq_if seq ();
   cit_res_t res;
   logic acc;
   logic [10:0] tot_clk;
   logic [7:0] tot_rd;
   logic [7:0] tot_wr;
   logic [10:0] clocks_ff;
   logic [7:0] reads_ff;
   logic [7:0] writes_ff;
   logic max_ff;
   logic illegal_ff;
   logic [10:0] el_ff;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic cit_class_t ea_class(input cit_mode_t m);
      cit_class_t c;
      c = C_NONE;
      unique case (m)
         M_IND, M_POSTINC, M_PREDEC: c = C_IND;
         M_DISP, M_ABS_SHORT, M_PC_DISP: c = C_D16;
         M_INDEX, M_PC_INDEX: c = C_IDX;
         M_ABS_LONG: c = C_ABSL;
         default: c = C_NONE;
      endcase
      return c;
   endfunction

   function automatic cit_tm_t add_n(input cit_tm_t b, input cit_tm_t s, input logic [5:0] n);
      cit_tm_t r;
      r.clk = b.clk + 11'(s.clk * 11'(n));
      r.rd = b.rd + 8'(s.rd * 8'(n));
      r.wr = b.wr + 8'(s.wr * 8'(n));
      return r;
   endfunction

   function automatic cit_tm_t pick4(input cit_class_t c, input cit_tm_t a, input cit_tm_t b,
                                     input cit_tm_t x, input cit_tm_t l);
      cit_tm_t r;
      r = a;
      unique case (c)
         C_D16: r = b;
         C_IDX: r = x;
         C_ABSL: r = l;
         default: r = a;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Timing table
   // ----------------------------------------
   function automatic cit_res_t calc(input cit_op_t op, input cit_size_t sz, input cit_mode_t m,
                                     input logic [5:0] n, input logic tk, input logic imm,
                                     input logic mem, input logic [3:0] iack);
      cit_res_t r;
      cit_class_t c;
      logic ctl_ok;
      r = '0;
      r.legal = 1'b1;
      c = ea_class(m);
      ctl_ok = (c != C_NONE) && ((c != C_IND) || (m == M_IND));
      unique case (op)
         OP_ARITH_SHIFT, OP_LOGIC_SHIFT, OP_ROTATE, OP_ROTATE_EXT: begin
            if (mem) begin
               r.tm = `CIT_T_SHIFT_MEM;
               r.ea_add = 1'b1;
               r.legal = (sz == SZ_WORD);
            end else begin
               r.tm = add_n((sz == SZ_LONG) ? `CIT_T_SHIFT_L : `CIT_T_SHIFT_BW, `CIT_T_SHIFT_STEP, n);
            end
         end
         OP_BIT_TOGGLE, OP_BIT_CLEAR, OP_BIT_SET: begin
            if (mem) begin
               r.tm = imm ? `CIT_T_BIT_MEM_IMM : `CIT_T_BIT_MEM_DYN;
               r.ea_add = 1'b1;
               r.legal = (sz == SZ_BYTE);
            end else begin
               if (op == OP_BIT_CLEAR) begin
                  r.tm = imm ? `CIT_T_BIT_CLEAR_REG_IMM : `CIT_T_BIT_CLEAR_REG_DYN;
               end else begin
                  r.tm = imm ? `CIT_T_BIT_REG_IMM : `CIT_T_BIT_REG_DYN;
               end
               r.max_val = 1'b1;
               r.legal = (sz == SZ_LONG);
            end
         end
         OP_COND_BRANCH: begin
            if (tk) begin
               r.tm = `CIT_T_BR_TAKEN;
            end else begin
               r.tm = (sz == SZ_BYTE) ? `CIT_T_BR_NOT_B : `CIT_T_BR_NOT_W;
            end
            r.legal = (sz != SZ_LONG);
         end
         OP_UNCOND_JUMP: begin
            r.tm = pick4(c, `CIT_T_JMP_IND, `CIT_T_JMP_D16, `CIT_T_JMP_IDX, `CIT_T_JMP_ABSL);
            r.legal = ctl_ok;
         end
         OP_SUBROUTINE_CALL: begin
            r.tm = pick4(c, `CIT_T_JSR_IND, `CIT_T_JSR_D16, `CIT_T_JSR_IDX, `CIT_T_JSR_ABSL);
            r.legal = ctl_ok;
         end
         OP_LOAD_EFF_ADDR: begin
            r.tm = pick4(c, `CIT_T_LEA_IND, `CIT_T_LEA_D16, `CIT_T_LEA_IDX, `CIT_T_LEA_ABSL);
            r.legal = ctl_ok;
         end
         OP_PUSH_EFF_ADDR: begin
            r.tm = pick4(c, `CIT_T_PEA_IND, `CIT_T_PEA_D16, `CIT_T_PEA_IDX, `CIT_T_PEA_ABSL);
            r.legal = ctl_ok;
         end
         OP_MULTI_LOAD: begin
            r.tm = add_n(pick4(c, `CIT_T_MLD_IND, `CIT_T_MLD_D16, `CIT_T_MLD_IDX, `CIT_T_MLD_ABSL),
                         (sz == SZ_LONG) ? `CIT_T_MLD_STEP_L : `CIT_T_MLD_STEP_W, n);
            r.legal = (c != C_NONE) && (m != M_PREDEC) && (sz != SZ_BYTE);
         end
         OP_MULTI_STORE: begin
            r.tm = add_n(pick4(c, `CIT_T_MST_IND, `CIT_T_MST_D16, `CIT_T_MST_IDX, `CIT_T_MST_ABSL),
                         (sz == SZ_LONG) ? `CIT_T_MST_STEP_L : `CIT_T_MST_STEP_W, n);
            r.legal = (c != C_NONE) && (m != M_POSTINC) && (m != M_PC_DISP) && (m != M_PC_INDEX)
                      && (sz != SZ_BYTE);
         end
         OP_MULTI_PREC: begin
            if (mem) begin
               r.tm = (sz == SZ_LONG) ? `CIT_T_MP_MEM_L : `CIT_T_MP_MEM_BW;
            end else begin
               r.tm = (sz == SZ_LONG) ? `CIT_T_MP_REG_L : `CIT_T_MP_REG_BW;
            end
         end
         OP_STATUS_READ: begin
            r.tm = mem ? `CIT_T_SR_RD_MEM : `CIT_T_SR_RD_REG;
            r.ea_add = mem;
         end
         OP_COND_CODE_WRITE, OP_STATUS_WRITE: begin
            r.tm = `CIT_T_SR_WR;
            r.ea_add = mem;
         end
         OP_ALT_BYTE_MOVE: begin
            r.tm = (sz == SZ_LONG) ? `CIT_T_ALT_L : `CIT_T_ALT_W;
            r.legal = (sz != SZ_BYTE);
         end
         OP_REG_EXCHANGE: r.tm = `CIT_T_EXG;
         OP_LINK_FRAME: r.tm = `CIT_T_LINK;
         OP_USER_STACK_PTR, OP_NO_OPERATION: r.tm = `CIT_T_SHORT;
         OP_EXT_RESET: r.tm = `CIT_T_EXT_RESET;
         OP_EXCEPTION_RETURN, OP_RETURN_RESTORE: r.tm = `CIT_T_RTE;
         OP_SUB_RETURN: r.tm = `CIT_T_RTS;
         OP_EXC_ADDR, OP_EXC_BUS: r.tm = `CIT_T_EXC_FAULT;
         OP_EXC_INT: begin
            r.tm = `CIT_T_EXC_INT;
            if (iack > `CIT_IACK_NOM_CLK) begin
               r.tm.clk = r.tm.clk + 11'(iack - `CIT_IACK_NOM_CLK);
            end
         end
         OP_EXC_ILLEGAL, OP_EXC_PRIV, OP_EXC_TRACE: r.tm = `CIT_T_EXC_PLAIN;
         default: r.legal = 1'b0;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Request decode and totals
   // ----------------------------------------
   assign res = calc(op_in, size_in, mode_in, count_in, taken_in, imm_bit_in, mem_form_in, iack_clk_in);
   assign acc = start_in && !seq.busy;
   assign tot_clk = res.tm.clk + (res.ea_add ? {3'h0, ea_clk_in} : 11'h000);
   assign tot_rd = res.tm.rd + (res.ea_add ? {4'h0, ea_rd_in} : 8'h00);
   assign tot_wr = res.tm.wr + (res.ea_add ? {4'h0, ea_wr_in} : 8'h00);

   assign seq.load = acc && res.legal;
   assign seq.total = tot_clk;
   assign seq.stop = early_in && max_ff;

   cit_cycle_cnt u_cnt (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .seq(seq)
   );

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         clocks_ff <= 11'h000;
         reads_ff <= 8'h00;
         writes_ff <= 8'h00;
         max_ff <= 1'b0;
      end else if (acc) begin
         clocks_ff <= tot_clk;
         reads_ff <= tot_rd;
         writes_ff <= tot_wr;
         max_ff <= res.max_val && res.legal;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         illegal_ff <= 1'b0;
      end else begin
         illegal_ff <= acc && !res.legal;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         el_ff <= 11'h000;
      end else if (seq.load) begin
         el_ff <= 11'h000;
      end else if (seq.busy) begin
         el_ff <= el_ff + 11'h001;
      end
   end

   assign ready_out = !seq.busy;
   assign busy_out = seq.busy;
   assign done_out = seq.last;
   assign illegal_out = illegal_ff;
   assign clocks_out = clocks_ff;
   assign reads_out = reads_ff;
   assign writes_out = writes_ff;
   assign max_out = max_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   shift_reg_a: assert property (acc && op_in == OP_ROTATE && !mem_form_in && size_in == SZ_WORD
      |=> clocks_out == 11'h006 + {4'h0, $past(count_in), 1'b0} && reads_out == 8'h01)
      else $error("register shift timing wrong");
   shift_long_a: assert property (acc && op_in == OP_ARITH_SHIFT && !mem_form_in && size_in == SZ_LONG
      |=> clocks_out == 11'h008 + {4'h0, $past(count_in), 1'b0})
      else $error("long shift timing wrong");
   shift_mem_a: assert property (acc && op_in == OP_LOGIC_SHIFT && mem_form_in && size_in == SZ_LONG
      |=> illegal_out && !busy_out)
      else $error("long memory shift accepted");
   bit_mem_a: assert property (acc && op_in == OP_BIT_SET && mem_form_in && imm_bit_in && size_in == SZ_BYTE
      |=> clocks_out == 11'h00D + {3'h0, $past(ea_clk_in)} && writes_out == 8'h01 + {4'h0, $past(ea_wr_in)})
      else $error("bit memory timing wrong");
   bit_clear_a: assert property (acc && op_in == OP_BIT_CLEAR && !mem_form_in && imm_bit_in && size_in == SZ_LONG
      |=> clocks_out == 11'h00E && reads_out == 8'h02 && max_out)
      else $error("bit clear timing wrong");
   branch_nt_a: assert property (acc && op_in == OP_COND_BRANCH && !taken_in && size_in == SZ_WORD
      |=> clocks_out == 11'h00C && reads_out == 8'h02)
      else $error("branch not taken timing wrong");
   jump_idx_a: assert property (acc && op_in == OP_UNCOND_JUMP && (mode_in == M_INDEX || mode_in == M_PC_INDEX)
      |=> clocks_out == 11'h00E && reads_out == 8'h03)
      else $error("indexed jump timing wrong");
   call_wr_a: assert property (acc && op_in == OP_SUBROUTINE_CALL && mode_in == M_ABS_LONG
      |=> clocks_out == 11'h016 && writes_out == 8'h02)
      else $error("call timing wrong");
   lea_ind_a: assert property (acc && op_in == OP_LOAD_EFF_ADDR && mode_in == M_IND
      |=> clocks_out == 11'h004 && writes_out == 8'h00)
      else $error("load address timing wrong");
   pea_disp_a: assert property (acc && op_in == OP_PUSH_EFF_ADDR && mode_in == M_DISP
      |=> clocks_out == 11'h012 && writes_out == 8'h02)
      else $error("push address timing wrong");
   mload_w_a: assert property (acc && op_in == OP_MULTI_LOAD && mode_in == M_IND && size_in == SZ_WORD
      |=> clocks_out == 11'h00C + {3'h0, $past(count_in), 2'h0} && reads_out == 8'h03 + {2'h0, $past(count_in)})
      else $error("multi load timing wrong");
   mstore_pi_a: assert property (acc && op_in == OP_MULTI_STORE && mode_in == M_POSTINC
      |=> illegal_out ##1 !busy_out)
      else $error("postincrement store accepted");
   mprec_ea_a: assert property (acc && op_in == OP_MULTI_PREC && mem_form_in && size_in == SZ_LONG
      |=> clocks_out == 11'h01E)
      else $error("multi-precision added address time");
   fault_exc_a: assert property (acc && (op_in == OP_EXC_ADDR || op_in == OP_EXC_BUS)
      |=> clocks_out == 11'h039 && reads_out == 8'h04 && writes_out == 8'h07)
      else $error("fault exception timing wrong");
   int_exc_a: assert property (acc && op_in == OP_EXC_INT
      |=> clocks_out == 11'h02F + (($past(iack_clk_in) > 4'h4) ? {7'h00, $past(iack_clk_in)} - 11'h004 : 11'h000))
      else $error("interrupt timing wrong");
   trace_exc_a: assert property (acc && op_in == OP_EXC_TRACE
      |=> clocks_out == 11'h025 && writes_out == 8'h03 ##[1:40] done_out)
      else $error("trace exception timing wrong");
   ext_reset_a: assert property (acc && op_in == OP_EXT_RESET
      |=> clocks_out == 11'h084 && reads_out == 8'h01)
      else $error("reset instruction timing wrong");
   returns_a: assert property (acc && op_in == OP_RETURN_RESTORE
      |=> clocks_out == 11'h014 && reads_out == 8'h05)
      else $error("return timing wrong");
   alt_long_a: assert property (acc && op_in == OP_ALT_BYTE_MOVE && size_in == SZ_LONG
      |=> clocks_out == 11'h01C && writes_out == 8'h04)
      else $error("alternate byte move timing wrong");
   sr_read_a: assert property (acc && op_in == OP_STATUS_READ && !mem_form_in
      |=> clocks_out == 11'h006)
      else $error("status read timing wrong");
   nop_len_a: assert property (acc && op_in == OP_NO_OPERATION
      |=> busy_out [*4] ##1 !busy_out)
      else $error("no-operation length wrong");
   run_len_a: assert property (done_out && !seq.stop |-> el_ff + 11'h001 == clocks_out)
      else $error("run length differs from count");
   early_max_a: assert property (done_out && el_ff + 11'h001 != clocks_out |-> max_out)
      else $error("early finish on exact entry");

   int_cov_c: cover property (acc && op_in == OP_EXC_INT ##1 busy_out);
   early_cov_c: cover property (done_out && seq.stop && el_ff + 11'h001 != clocks_out);
   multi_reg_move_cov_c: cover property (acc && op_in == OP_MULTI_STORE && size_in == SZ_LONG ##1 busy_out);
   illegal_cov_c: cover property (illegal_out);
endmodule

// *** tb/cit_mem_model.sv ***
`timescale 1ns/1ps
module cit_mem_model (
   input wire logic slow_in,
   input wire logic quick_in,
   output logic [3:0] iack_clk_out,
   output logic early_out
);
   // Acknowledge cycle length
   assign iack_clk_out = slow_in ? 4'h6 : 4'h4;
   // Operand allows early end
   assign early_out = quick_in;
endmodule

// *** tb/cit_timing_tb.sv ***
`timescale 1ns/1ps
module cit_timing_tb;
   import cit_pkg::*;
   logic mclk_in = 0, rst_in = 1, start = 0, tk = 0, imm = 0, mem = 0, slow = 0, quick = 0;
   cit_op_t op = OP_NO_OPERATION;
   cit_size_t sz = SZ_WORD;
   cit_mode_t md = M_DATA_REG;
   logic [5:0] n = 6'h00;
   logic [7:0] eac = 8'h00;
   logic [3:0] ear = 4'h0, eaw = 4'h0, iack;
   logic rdy, busy, done, ill, mx, early;
   logic [10:0] clk_o;
   logic [7:0] rd_o, wr_o;
   int num_errors = 0, samples_checked = 0;
   cit_mem_model mm (.slow_in(slow), .quick_in(quick), .iack_clk_out(iack), .early_out(early));
   cit_timing dut (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start), .op_in(op), .size_in(sz),
      .mode_in(md), .count_in(n), .taken_in(tk), .imm_bit_in(imm), .mem_form_in(mem), .ea_clk_in(eac),
      .ea_rd_in(ear), .ea_wr_in(eaw), .iack_clk_in(iack), .early_in(early), .ready_out(rdy),
      .busy_out(busy), .done_out(done), .illegal_out(ill), .clocks_out(clk_o), .reads_out(rd_o),
      .writes_out(wr_o), .max_out(mx));
   initial forever #4 mclk_in = ~mclk_in;
   task chk(input string nm, input logic [10:0] e, input logic [10:0] s);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s exp %0h got %0h", nm, e, s);
      end
   endtask
   task go(input cit_op_t o, input cit_size_t s, input cit_mode_t m, input logic [5:0] k,
      input logic [10:0] c, input logic [7:0] r, input logic [7:0] w, input logic il);
      int cnt;
      int dn;
      op = o;
      sz = s;
      md = m;
      n = k;
      start = 1;
      @(posedge mclk_in);
      #1;
      start = 0;
      chk("illegal", {10'h000, il}, {10'h000, ill});
      chk("ready", {10'h000, il}, {10'h000, rdy});
      chk("max", {10'h000, !il && !mem && (o inside {OP_BIT_TOGGLE, OP_BIT_CLEAR, OP_BIT_SET})},
         {10'h000, mx});
      cnt = 0;
      dn = 0;
      if (!il) begin
         chk("clocks", c, clk_o);
         chk("reads", {3'h0, r}, {3'h0, rd_o});
         chk("writes", {3'h0, w}, {3'h0, wr_o});
      end
      while (busy === 1'b1 && cnt < 300) begin
         dn += (done === 1'b1);
         cnt++;
         @(posedge mclk_in);
         #1;
      end
      if (il) begin
         @(posedge mclk_in);
         #1;
      end
      chk("busy cycles", il ? 11'h000 : quick ? 11'h001 : c, 11'(cnt));
      chk("done pulses", {10'h000, !il}, 11'(dn));
      chk("illegal end", 11'h000, {10'h000, ill});
   endtask
   task t_shift;
      go(OP_ARITH_SHIFT, SZ_WORD, M_DATA_REG, 6'h03, 11'h00C, 8'h01, 8'h00, 0);
      go(OP_LOGIC_SHIFT, SZ_BYTE, M_DATA_REG, 6'h3F, 11'h084, 8'h01, 8'h00, 0);
      go(OP_ROTATE_EXT, SZ_LONG, M_DATA_REG, 6'h00, 11'h008, 8'h01, 8'h00, 0);
      go(OP_ROTATE, SZ_WORD, M_DATA_REG, 6'h05, 11'h010, 8'h01, 8'h00, 0);
      go(OP_ARITH_SHIFT, SZ_LONG, M_DATA_REG, 6'h02, 11'h00C, 8'h01, 8'h00, 0);
   endtask
   task t_mem;
      mem = 1;
      eac = 8'h04;
      ear = 4'h1;
      eaw = 4'h2;
      go(OP_ROTATE, SZ_WORD, M_IND, 6'h00, 11'h00D, 8'h02, 8'h03, 0);
      go(OP_LOGIC_SHIFT, SZ_LONG, M_IND, 6'h00, 11'h000, 8'h00, 8'h00, 1);
      imm = 1;
      go(OP_BIT_TOGGLE, SZ_BYTE, M_IND, 6'h00, 11'h011, 8'h03, 8'h03, 0);
      go(OP_BIT_SET, SZ_BYTE, M_IND, 6'h00, 11'h011, 8'h03, 8'h03, 0);
      go(OP_MULTI_PREC, SZ_LONG, M_IND, 6'h00, 11'h01E, 8'h05, 8'h02, 0);
      go(OP_STATUS_READ, SZ_WORD, M_IND, 6'h00, 11'h00D, 8'h02, 8'h03, 0);
      mem = 0;
      go(OP_BIT_CLEAR, SZ_LONG, M_DATA_REG, 6'h00, 11'h00E, 8'h02, 8'h00, 0);
      imm = 0;
      quick = 1;
      go(OP_BIT_SET, SZ_LONG, M_DATA_REG, 6'h00, 11'h008, 8'h01, 8'h00, 0);
      quick = 0;
   endtask
   task t_flow;
      tk = 1;
      go(OP_COND_BRANCH, SZ_WORD, M_IND, 6'h00, 11'h00A, 8'h01, 8'h00, 0);
      tk = 0;
      go(OP_COND_BRANCH, SZ_BYTE, M_IND, 6'h00, 11'h008, 8'h01, 8'h00, 0);
      go(OP_COND_BRANCH, SZ_WORD, M_IND, 6'h00, 11'h00C, 8'h02, 8'h00, 0);
      go(OP_UNCOND_JUMP, SZ_WORD, M_INDEX, 6'h00, 11'h00E, 8'h03, 8'h00, 0);
      go(OP_SUBROUTINE_CALL, SZ_WORD, M_ABS_LONG, 6'h00, 11'h016, 8'h03, 8'h02, 0);
      go(OP_LOAD_EFF_ADDR, SZ_WORD, M_DISP, 6'h00, 11'h008, 8'h02, 8'h00, 0);
      go(OP_PUSH_EFF_ADDR, SZ_WORD, M_INDEX, 6'h00, 11'h016, 8'h02, 8'h02, 0);
      go(OP_LOAD_EFF_ADDR, SZ_WORD, M_IND, 6'h00, 11'h004, 8'h01, 8'h00, 0);
      go(OP_PUSH_EFF_ADDR, SZ_WORD, M_DISP, 6'h00, 11'h012, 8'h02, 8'h02, 0);
   endtask
   task t_multi;
      go(OP_MULTI_LOAD, SZ_LONG, M_IND, 6'h02, 11'h01C, 8'h07, 8'h00, 0);
      go(OP_MULTI_LOAD, SZ_WORD, M_IND, 6'h04, 11'h01C, 8'h07, 8'h00, 0);
      go(OP_MULTI_STORE, SZ_WORD, M_PREDEC, 6'h03, 11'h017, 8'h02, 8'h03, 0);
      go(OP_MULTI_STORE, SZ_WORD, M_POSTINC, 6'h01, 11'h000, 8'h00, 8'h00, 1);
   endtask
   task t_exc;
      go(OP_EXC_BUS, SZ_WORD, M_IND, 6'h00, 11'h039, 8'h04, 8'h07, 0);
      go(OP_EXC_INT, SZ_WORD, M_IND, 6'h00, 11'h02F, 8'h05, 8'h03, 0);
      slow = 1;
      go(OP_EXC_INT, SZ_WORD, M_IND, 6'h00, 11'h031, 8'h05, 8'h03, 0);
      slow = 0;
      go(OP_EXC_TRACE, SZ_WORD, M_IND, 6'h00, 11'h025, 8'h04, 8'h03, 0);
      go(OP_EXC_ILLEGAL, SZ_WORD, M_IND, 6'h00, 11'h025, 8'h04, 8'h03, 0);
      go(OP_EXT_RESET, SZ_WORD, M_IND, 6'h00, 11'h084, 8'h01, 8'h00, 0);
   endtask
   task t_misc;
      go(OP_RETURN_RESTORE, SZ_WORD, M_IND, 6'h00, 11'h014, 8'h05, 8'h00, 0);
      go(OP_SUB_RETURN, SZ_WORD, M_IND, 6'h00, 11'h010, 8'h04, 8'h00, 0);
      go(OP_ALT_BYTE_MOVE, SZ_LONG, M_DISP, 6'h00, 11'h01C, 8'h02, 8'h04, 0);
      go(OP_STATUS_WRITE, SZ_WORD, M_DATA_REG, 6'h00, 11'h00C, 8'h02, 8'h00, 0);
      go(OP_LINK_FRAME, SZ_WORD, M_IND, 6'h00, 11'h012, 8'h02, 8'h02, 0);
      go(OP_REG_EXCHANGE, SZ_WORD, M_IND, 6'h00, 11'h006, 8'h01, 8'h00, 0);
      go(OP_EXCEPTION_RETURN, SZ_WORD, M_IND, 6'h00, 11'h014, 8'h05, 8'h00, 0);
      go(OP_STATUS_READ, SZ_WORD, M_DATA_REG, 6'h00, 11'h006, 8'h01, 8'h00, 0);
      go(OP_NO_OPERATION, SZ_WORD, M_IND, 6'h00, 11'h004, 8'h01, 8'h00, 0);
   endtask
   task results;
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      results;
   end
   initial begin
      repeat (12) @(posedge mclk_in);
      #1;
      rst_in = 0;
      t_shift;
      t_mem;
      t_flow;
      t_multi;
      t_exc;
      t_misc;
      results;
   end
endmodule
